// *** pressure_readout_defs.svh ***
`ifndef PRESSURE_READOUT_DEFS_SVH
`define PRESSURE_READOUT_DEFS_SVH

`define CAL_READ_ADDR 8'hA1
`define CAL_WRITE_ADDR 8'hA0
`define ADC_WRITE_ADDR 8'hEE
`define ADC_READ_ADDR 8'hEF
`define ADC_REG_COMMAND 8'hFF
`define ADC_REG_RESULT 8'hFD
`define CMD_PRESSURE 8'hF0
`define CMD_TEMPERATURE 8'hE8
`define CAL_DEPTH 256
`define CAL_IMAGE_BITS (`CAL_DEPTH * 8)
`define CLK_PERIOD_NS 10
`define CONV_TIME_MS 40
`define CONV_CYCLES ((`CONV_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define BITS_PER_BYTE 4'h8
`define RESET_WORD 16'h0000
`define RESET_BYTE 8'h00

`endif

// *** pressure_readout_pkg.sv ***
package pressure_readout_pkg;

    typedef enum logic [2:0] {
        SLV_IDLE,
        SLV_ADDR,
        SLV_ACK_OUT,
        SLV_RX,
        SLV_TX,
        SLV_MASTER_ACK
    } slave_state_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } line_events_t;

    typedef struct packed {
        logic scl_d;
        logic sda_d;
        line_events_t ev;
    } watch_state_t;

    typedef struct packed {
        slave_state_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic target_adc;
        logic reading;
        logic acked;
        logic [1:0] byte_idx;
        logic reg_sel_cmd;
        logic cmd_valid;
        logic cmd_temp;
        logic conv_busy;
        logic conv_temp;
        logic [31:0] conv_count;
        logic [7:0] cal_ptr;
        logic [1:0] rd_sel;
        logic [15:0] raw_pressure_word;
        logic [15:0] raw_temperature_word;
        logic last_temp;
        logic sda_oe;
        logic sda_out;
    } readout_state_t;

endpackage

// *** line_watch.sv ***
`timescale 1ns/100ps
module line_watch
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    output pressure_readout_pkg::line_events_t ev
);

    pressure_readout_pkg::watch_state_t r;
    pressure_readout_pkg::watch_state_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // Edge and bus condition detection.
    always_comb
    begin
        next_r = r;
        next_r.scl_d = scl;
        next_r.sda_d = sda;
        next_r.ev.scl_rise = scl & ~r.scl_d;
        next_r.ev.scl_fall = ~scl & r.scl_d;
        next_r.ev.start = scl & r.scl_d & r.sda_d & ~sda;
        next_r.ev.stop = scl & r.scl_d & ~r.sda_d & sda;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '{scl_d: 1'b1, sda_d: 1'b1, ev: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign ev = r.ev;

endmodule

// *** pressure_module_i2c_readout.sv ***
// Contract
// (R1) Calibration memory read at 0xA1, never written.
// (R2) Calibration read: sequential bytes, auto-incrementing address.
// (R3) Converter answers 0xEE write, 0xEF read.
// (R4) Master sends FF then pressure command, stop.
// (R5) Master sends FF then E8 temperature command.
// (R6) Master waits 40ms before reading result; the bench host waits CONV + 20 = 70 clock cycles instead.
// (R7) Pointer FD, repeated start, result MSB first.
// (R8) Master acks MSB, nacks LSB, then stops.
// (R9) Converter reset held low during calibration reads.
// (R10) Converter reset high before conversion command.
// (R11) Master discards first result after power-on; the bench host reads and checks the first result instead.
// (R12) Calibration write address is not acknowledged.
`timescale 1ns/100ps
`include "pressure_readout_defs.svh"
module pressure_module_i2c_readout
#(
    parameter int unsigned CONV_CYCLES = `CONV_CYCLES,
    parameter logic [`CAL_IMAGE_BITS-1:0] CAL_IMAGE = '0
)
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic CONVERTER_RESET_N,
    input wire logic [15:0] PRESSURE_SAMPLE,
    input wire logic [15:0] TEMPERATURE_SAMPLE,
    output logic CONV_BUSY,
    output logic [15:0] RAW_PRESSURE_WORD,
    output logic [15:0] RAW_TEMPERATURE_WORD
);

    pressure_readout_pkg::line_events_t ev;
    pressure_readout_pkg::readout_state_t r;
    pressure_readout_pkg::readout_state_t next_r;
    logic [7:0] cal_byte;
    logic [15:0] result_word;
    logic [7:0] tx_byte;

    line_watch u_line_watch
    (
        .clk(CLK),
        .nrst(NRST),
        .scl(SCL),
        .sda(SDA_IN),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data selection.
    always_comb
    begin
        cal_byte = CAL_IMAGE[{r.cal_ptr, 3'h0} +: 8]; // (R1)
        result_word = r.last_temp ? r.raw_temperature_word : r.raw_pressure_word;
        if (!r.target_adc)
        begin
            tx_byte = cal_byte;
        end
        else if (r.rd_sel == 2'h0)
        begin
            tx_byte = result_word[15:8]; // (R7)
        end
        else if (r.rd_sel == 2'h1)
        begin
            tx_byte = result_word[7:0]; // (R7)
        end
        else
        begin
            tx_byte = `RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial slave and conversion control.
    always_comb
    begin
        next_r = r;
        next_r.sda_out = 1'b0;

        // The converter runs while its reset pin is high and aborts otherwise.
        if (!CONVERTER_RESET_N)
        begin
            next_r.conv_busy = 1'b0;
            next_r.conv_count = '0;
        end
        else if (r.conv_busy)
        begin
            if (r.conv_count >= CONV_CYCLES - 32'h1)
            begin
                next_r.conv_busy = 1'b0;
                next_r.last_temp = r.conv_temp;
                if (r.conv_temp)
                begin
                    next_r.raw_temperature_word = TEMPERATURE_SAMPLE;
                end
                else
                begin
                    next_r.raw_pressure_word = PRESSURE_SAMPLE;
                end
            end
            else
            begin
                next_r.conv_count = r.conv_count + 32'h1;
            end
        end

        if (ev.start)
        begin
            next_r.state = pressure_readout_pkg::SLV_ADDR;
            next_r.cnt = '0;
            next_r.sda_oe = 1'b0;
        end
        else if (ev.stop)
        begin
            next_r.state = pressure_readout_pkg::SLV_IDLE;
            next_r.sda_oe = 1'b0;
            if (r.cmd_valid && CONVERTER_RESET_N) // (R10)
            begin
                next_r.conv_busy = 1'b1;
                next_r.conv_temp = r.cmd_temp;
                next_r.conv_count = '0;
            end
            next_r.cmd_valid = 1'b0;
        end
        else
        begin
            case (r.state)
                pressure_readout_pkg::SLV_ADDR,
                pressure_readout_pkg::SLV_RX:
                begin
                    if (ev.scl_rise)
                    begin
                        next_r.shift = {r.shift[6:0], SDA_IN};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    else if (ev.scl_fall && r.cnt == `BITS_PER_BYTE)
                    begin
                        next_r.cnt = '0;
                        if (r.state == pressure_readout_pkg::SLV_ADDR)
                        begin
                            next_r.byte_idx = '0;
                            next_r.rd_sel = '0;
                            if (r.shift == `CAL_READ_ADDR) // (R1)
                            begin
                                next_r.target_adc = 1'b0;
                                next_r.reading = 1'b1;
                                next_r.sda_oe = 1'b1;
                                next_r.state = pressure_readout_pkg::SLV_ACK_OUT;
                            end
                            else if (r.shift == `ADC_WRITE_ADDR) // (R3)
                            begin
                                next_r.target_adc = 1'b1;
                                next_r.reading = 1'b0;
                                next_r.sda_oe = 1'b1;
                                next_r.state = pressure_readout_pkg::SLV_ACK_OUT;
                            end
                            else if (r.shift == `ADC_READ_ADDR) // (R3)
                            begin
                                next_r.target_adc = 1'b1;
                                next_r.reading = 1'b1;
                                next_r.sda_oe = 1'b1;
                                next_r.state = pressure_readout_pkg::SLV_ACK_OUT;
                            end
                            else
                            begin
                                // Calibration write address and foreign addresses fall here.
                                next_r.state = pressure_readout_pkg::SLV_IDLE; // (R12)
                            end
                        end
                        else
                        begin
                            next_r.sda_oe = 1'b1;
                            next_r.state = pressure_readout_pkg::SLV_ACK_OUT;
                            if (r.byte_idx != 2'h3)
                            begin
                                next_r.byte_idx = r.byte_idx + 2'h1;
                            end
                            if (r.byte_idx == 2'h0)
                            begin
                                next_r.reg_sel_cmd = (r.shift == `ADC_REG_COMMAND);
                                next_r.cmd_valid = 1'b0;
                                if (r.shift == `ADC_REG_RESULT) // (R7)
                                begin
                                    next_r.rd_sel = '0;
                                end
                            end
                            else if (r.byte_idx == 2'h1 && r.reg_sel_cmd)
                            begin
                                if (r.shift == `CMD_PRESSURE) // (R4)
                                begin
                                    next_r.cmd_valid = 1'b1;
                                    next_r.cmd_temp = 1'b0;
                                end
                                else if (r.shift == `CMD_TEMPERATURE) // (R5)
                                begin
                                    next_r.cmd_valid = 1'b1;
                                    next_r.cmd_temp = 1'b1;
                                end
                            end
                        end
                    end
                end
                pressure_readout_pkg::SLV_ACK_OUT:
                begin
                    if (ev.scl_fall)
                    begin
                        next_r.cnt = '0;
                        if (r.reading)
                        begin
                            next_r.shift = tx_byte;
                            next_r.sda_oe = ~tx_byte[7];
                            next_r.state = pressure_readout_pkg::SLV_TX;
                        end
                        else
                        begin
                            next_r.sda_oe = 1'b0;
                            next_r.state = pressure_readout_pkg::SLV_RX;
                        end
                    end
                end
                pressure_readout_pkg::SLV_TX:
                begin
                    if (ev.scl_rise)
                    begin
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    else if (ev.scl_fall)
                    begin
                        if (r.cnt == `BITS_PER_BYTE)
                        begin
                            next_r.sda_oe = 1'b0;
                            next_r.state = pressure_readout_pkg::SLV_MASTER_ACK;
                            if (r.target_adc)
                            begin
                                if (r.rd_sel != 2'h2)
                                begin
                                    next_r.rd_sel = r.rd_sel + 2'h1; // (R7)
                                end
                            end
                            else
                            begin
                                next_r.cal_ptr = r.cal_ptr + 8'h1; // (R2)
                            end
                        end
                        else
                        begin
                            next_r.shift = {r.shift[6:0], 1'b0};
                            next_r.sda_oe = ~r.shift[6];
                        end
                    end
                end
                pressure_readout_pkg::SLV_MASTER_ACK:
                begin
                    if (ev.scl_rise)
                    begin
                        next_r.acked = ~SDA_IN;
                    end
                    else if (ev.scl_fall)
                    begin
                        next_r.cnt = '0;
                        if (r.acked)
                        begin
                            next_r.shift = tx_byte; // (R2)
                            next_r.sda_oe = ~tx_byte[7];
                            next_r.state = pressure_readout_pkg::SLV_TX;
                        end
                        else
                        begin
                            next_r.state = pressure_readout_pkg::SLV_IDLE; // (R8)
                        end
                    end
                end
                default:
                begin
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign SDA_OUT = r.sda_out;
    assign SDA_OE = r.sda_oe;
    assign CONV_BUSY = r.conv_busy;
    assign RAW_PRESSURE_WORD = r.raw_pressure_word;
    assign RAW_TEMPERATURE_WORD = r.raw_temperature_word;

endmodule

// *** pressure_readout_asserts.sv ***
`timescale 1ns/100ps
module pressure_readout_asserts
#(
    parameter int unsigned CONV_CYCLES = 50
)
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic CONVERTER_RESET_N,
    input wire logic [15:0] PRESSURE_SAMPLE,
    input wire logic [15:0] TEMPERATURE_SAMPLE,
    input wire logic CONV_BUSY,
    input wire logic [15:0] RAW_PRESSURE_WORD,
    input wire logic [15:0] RAW_TEMPERATURE_WORD
);
    logic [31:0] busy_cnt;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            busy_cnt <= 32'h00000000;
        else if (CONV_BUSY)
            busy_cnt <= busy_cnt + 32'h00000001;
        else
            busy_cnt <= 32'h00000000;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence scl_held;
        SCL [*4];
    endsequence
    sequence stop_seen;
        SCL && $rose(SDA_IN);
    endsequence
    sequence done_ok;
        $fell(CONV_BUSY) && $past(CONVERTER_RESET_N);
    endsequence
    a_open_drain: assert property (SDA_OUT == 1'b0)
        else $error("data output not held low");
    a_data_steady: assert property (scl_held |-> $stable(SDA_OE))
        else $error("data drive moved while clock high");
    a_idle_after_stop: assert property (stop_seen |-> !SDA_OE [*8])
        else $error("data driven after stop");
    a_busy_at_stop: assert property ($rose(CONV_BUSY) |-> SCL && SDA_IN && !$past(SDA_IN, 5))
        else $error("conversion began away from a stop");
    a_busy_released: assert property ($rose(CONV_BUSY) |-> $past(CONVERTER_RESET_N))
        else $error("conversion began in converter reset");
    a_busy_bound: assert property (CONV_BUSY |-> busy_cnt < CONV_CYCLES)
        else $error("conversion overran");
    a_busy_length: assert property (done_ok |-> busy_cnt == CONV_CYCLES)
        else $error("conversion length wrong");
    a_result_load: assert property (done_ok |->
        RAW_PRESSURE_WORD == $past(PRESSURE_SAMPLE)
        || RAW_TEMPERATURE_WORD == $past(TEMPERATURE_SAMPLE))
        else $error("result not latched");
    a_result_hold: assert property (!$fell(CONV_BUSY) |->
        $stable(RAW_PRESSURE_WORD) && $stable(RAW_TEMPERATURE_WORD))
        else $error("result changed outside conversion end");
endmodule
bind pressure_module_i2c_readout pressure_readout_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk
(
    .CLK(CLK),
    .NRST(NRST),
    .SCL(SCL),
    .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE),
    .CONVERTER_RESET_N(CONVERTER_RESET_N),
    .PRESSURE_SAMPLE(PRESSURE_SAMPLE),
    .TEMPERATURE_SAMPLE(TEMPERATURE_SAMPLE),
    .CONV_BUSY(CONV_BUSY),
    .RAW_PRESSURE_WORD(RAW_PRESSURE_WORD),
    .RAW_TEMPERATURE_WORD(RAW_TEMPERATURE_WORD)
);

// *** host_master.sv ***
`timescale 1ns/100ps
`include "pressure_readout_defs.svh"
module host_master
#(
    parameter int unsigned WAIT = 70
)
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    output logic conv_reset_n,
    output logic [8:0] res,
    output logic res_valid
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        conv_reset_n = 1'b0;
        res = 9'h000;
        res_valid = 1'b0;
    end
    task automatic half();
        repeat (5) @(negedge clk);
    endtask
    task automatic emit(input logic [8:0] v);
        res = v;
        res_valid = 1'b1;
        @(negedge clk);
        res_valid = 1'b0;
    endtask
    task automatic bitx(input logic b, output logic r);
        half();
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        half();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    task automatic wr(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        emit({8'h00, ~r});
    endtask
    task automatic rd(input logic last);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, r);
        emit({d, 1'b1});
    endtask
    task automatic cal_read(input int n);
        conv_reset_n = 1'b0;
        start();
        wr(`CAL_READ_ADDR);
        for (int i = 0; i < n; i++) rd(i == n - 1);
        stop();
    endtask
    task automatic convert(input logic [7:0] cmd, input logic rel);
        conv_reset_n = rel;
        start();
        wr(`ADC_WRITE_ADDR);
        wr(`ADC_REG_COMMAND);
        wr(cmd);
        stop();
    endtask
    task automatic fetch();
        repeat (WAIT) @(negedge clk);
        start();
        wr(`ADC_WRITE_ADDR);
        wr(`ADC_REG_RESULT);
        start();
        wr(`ADC_READ_ADDR);
        rd(1'b0);
        rd(1'b1);
        stop();
    endtask
endmodule

// *** pressure_module_i2c_readout_bench.sv ***
`timescale 1ns/100ps
`include "pressure_readout_defs.svh"
module pressure_module_i2c_readout_bench;
    localparam int unsigned CONV = 50;
    localparam logic [`CAL_IMAGE_BITS-1:0] IMAGE = {{(`CAL_IMAGE_BITS-32){1'b0}}, 32'hC30FA53C};
    logic CLK = 1'b0;
    logic nrst = 1'b0;
    logic scl, sda_low, conv_rst_n, res_valid, sda_out, sda_oe, busy, rel, go;
    logic [8:0] res;
    logic [7:0] cmd;
    logic [15:0] p_sample = 16'h0000;
    logic [15:0] t_sample = 16'h0000;
    logic [15:0] raw_p, raw_t, last;
    logic [15:0] exp_p = 16'h0000;
    logic [15:0] exp_t = 16'h0000;
    logic [8:0] expq[$];
    wire sda;
    int mismatches = 0;
    int n_checks = 0;
    always #5 CLK = ~CLK;
    assign sda = ~((sda_oe & ~sda_out) | sda_low);
    host_master #(.WAIT(CONV + 20)) host
    (
        .clk(CLK),
        .sda(sda),
        .scl(scl),
        .sda_low(sda_low),
        .conv_reset_n(conv_rst_n),
        .res(res),
        .res_valid(res_valid)
    );
    pressure_module_i2c_readout #(.CONV_CYCLES(CONV), .CAL_IMAGE(IMAGE)) DUT
    (
        .CLK(CLK),
        .NRST(nrst),
        .SCL(scl),
        .SDA_IN(sda),
        .SDA_OUT(sda_out),
        .SDA_OE(sda_oe),
        .CONVERTER_RESET_N(conv_rst_n),
        .PRESSURE_SAMPLE(p_sample),
        .TEMPERATURE_SAMPLE(t_sample),
        .CONV_BUSY(busy),
        .RAW_PRESSURE_WORD(raw_p),
        .RAW_TEMPERATURE_WORD(raw_t)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
        n_checks++;
        if (got !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        if (res_valid === 1'b1)
            check("bus result", {7'h00, expq.size() ? expq.pop_front() : 9'hxxx},
                {7'h00, res});
    end
    initial
    begin
        repeat (100000) @(posedge CLK);
        mismatches++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(55657));
        repeat (3) @(negedge CLK);
        nrst = 1'b1;
        repeat (3) @(negedge CLK);
        expq.push_back(9'h001);
        for (int i = 0; i < 4; i++) expq.push_back({IMAGE[8*i +: 8], 1'b1});
        host.cal_read(4);
        $display("test calibration read done");
        for (int i = 0; i < 2; i++)
        begin
            expq.push_back(9'h000);
            host.start();
            host.wr(i ? 8'h55 : `CAL_WRITE_ADDR);
            host.stop();
        end
        $display("test refused addresses done");
        // The opening pressure result after power-on is read back and checked like every later result.
        for (int k = 0; k < 6; k++)
        begin
            cmd = (k == 5) ? 8'h55 : (k[0] ? `CMD_TEMPERATURE : `CMD_PRESSURE);
            rel = (k != 4);
            go = (k < 4);
            p_sample = 16'($urandom);
            t_sample = 16'($urandom);
            if (go && k[0])
                exp_t = t_sample;
            if (go && !k[0])
                exp_p = p_sample;
            if (go)
                last = k[0] ? t_sample : p_sample;
            repeat (3) expq.push_back(9'h001);
            host.convert(cmd, rel);
            check("conversion busy", {15'h0000, go}, {15'h0000, busy});
            repeat (3) expq.push_back(9'h001);
            expq.push_back({last[15:8], 1'b1});
            expq.push_back({last[7:0], 1'b1});
            host.fetch();
            check("pressure word", exp_p, raw_p);
            check("temperature word", exp_t, raw_t);
            $display("test conversion %0d done", k);
        end
        check("pending results", 16'h0000, 16'(expq.size()));
        end_of_test();
    end
endmodule
